// File: hw/sram_port_pkg.sv
package sram_port_pkg;
   // ----------------------------------------
   // geometry
   // ----------------------------------------
   localparam int ADDR_W = 8;
   localparam int LANES = 4;
   localparam int BYTE_W = 8;
   localparam int DATA_W = LANES * BYTE_W;
   localparam int DEPTH = 1 << ADDR_W;
   localparam logic [1:0] BEAT_STEP = 2'h1;
   localparam logic [LANES-1:0] LANES_OFF = 4'hf;
   localparam logic [3:0] PIPE_CYCLES = 4'h1;

   // ----------------------------------------
   // host operation codes
   // ----------------------------------------
   typedef enum logic [1:0] {
      OP_IDLE = 2'b00,
      OP_READ = 2'b01,
      OP_WRITE = 2'b10,
      OP_BURST = 2'b11
   } host_op_e;
endpackage

// File: hw/sram_port_if.sv
`timescale 1ns/100ps
interface sram_port_if;
   import sram_port_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [LANES-1:0] write_select_n;
   logic write_strobe_n;
   logic advance_or_load;
   logic clock_qualifier_n;
   logic chip_select_primary_n;
   logic chip_select_second;
   logic chip_select_third_n;
   logic output_enable_n;
   logic burst_order_interleaved;
   // shared data/parity wire, resolved from both enables (low = driving)
   logic [DATA_W-1:0] mem_dq_o;
   logic [LANES-1:0] mem_par_o;
   logic mem_drive_n;
   logic [DATA_W-1:0] host_dq_o;
   logic [LANES-1:0] host_par_o;
   logic host_drive_n;
   logic [DATA_W-1:0] dq_wire;
   logic [LANES-1:0] par_wire;
   assign dq_wire = !mem_drive_n ? mem_dq_o :
                    !host_drive_n ? host_dq_o : '1;
   assign par_wire = !mem_drive_n ? mem_par_o :
                     !host_drive_n ? host_par_o : '1;

   modport memory (
      input addr, write_select_n, write_strobe_n, advance_or_load,
      input clock_qualifier_n, chip_select_primary_n, chip_select_second,
      input chip_select_third_n, output_enable_n, burst_order_interleaved,
      input dq_wire, par_wire,
      output mem_dq_o, mem_par_o, mem_drive_n
   );
   modport host (
      output addr, write_select_n, write_strobe_n, advance_or_load,
      output clock_qualifier_n, chip_select_primary_n, chip_select_second,
      output chip_select_third_n, output_enable_n, burst_order_interleaved,
      input dq_wire, par_wire,
      output host_dq_o, host_par_o, host_drive_n
   );
endinterface

// File: hw/sram_port_memory.sv
`timescale 1ns/100ps
module sram_port_memory
   import sram_port_pkg::*;
(
   input wire logic i_core_clk,      // interface clock
   input wire logic i_sys_rst,       // clears the read data register only, not the array
   sram_port_if.memory bus           // link to controller
);
   // ----------------------------------------
   // storage and pipeline state
   // ----------------------------------------
   logic [ADDR_W-1:0] base_reg;
   logic [1:0] beat_reg;
   logic active_reg;
   logic is_write_reg;
   logic [LANES-1:0] lanes_reg;
   logic wake_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic [LANES-1:0] rd_par_reg;
   logic [ADDR_W-1:0] cur_addr;
   logic [1:0] next_beat;
   logic qual;
   logic selected;
   logic [ADDR_W-1:0] step_addr;
   logic [ADDR_W-1:0] rd_addr;
   logic [DATA_W-1:0] rd_data_next;
   logic [LANES-1:0] rd_par_next;
   logic wr_now;
   logic wr_hit;

   assign qual = !bus.clock_qualifier_n;
   assign selected = !bus.chip_select_primary_n && bus.chip_select_second
                     && !bus.chip_select_third_n;
   // interleaved order is xor with start beat; linear is plain increment
   assign next_beat = beat_reg + BEAT_STEP;
   assign cur_addr = bus.burst_order_interleaved ?
      {base_reg[ADDR_W-1:2], base_reg[1:0] ^ beat_reg} :
      {base_reg[ADDR_W-1:2], base_reg[1:0] + beat_reg};
   // a step reads the beat it moves to, not the one it leaves
   assign step_addr = bus.burst_order_interleaved ?
      {base_reg[ADDR_W-1:2], base_reg[1:0] ^ next_beat} :
      {base_reg[ADDR_W-1:2], base_reg[1:0] + next_beat};
   assign rd_addr = bus.advance_or_load ? step_addr : bus.addr;
   // write data phase lands on this edge
   assign wr_now = qual && active_reg && is_write_reg;
   // a read taken on the landing edge must see the new bytes
   assign wr_hit = wr_now && (cur_addr == rd_addr);

   // ----------------------------------------
   // control capture
   // ----------------------------------------
   // no reset on the array side: the real part has none
   always_ff @(posedge i_core_clk) begin
      if (qual) begin
         if (!bus.advance_or_load) begin
            active_reg <= selected;
            // cycle after a deselect is the deselect's own data phase
            wake_reg <= !selected;
            if (selected) begin
               base_reg <= bus.addr;
               beat_reg <= 2'h0;
               is_write_reg <= !bus.write_strobe_n;
               lanes_reg <= bus.write_select_n;
            end
         end else begin
            wake_reg <= !active_reg;
            if (active_reg) begin
               beat_reg <= next_beat;
               lanes_reg <= bus.write_select_n;
            end
         end
      end
   end

   // ----------------------------------------
   // data phase: write one cycle after command
   // ----------------------------------------
   // one byte plus its parity bit per lane, written in the data phase
   for (genvar l = 0; l < LANES; l++) begin : g_lane
      logic [BYTE_W:0] cell_reg [DEPTH];
      logic [BYTE_W:0] wr_cell;
      assign wr_cell = {bus.par_wire[l], bus.dq_wire[l*BYTE_W +: BYTE_W]};
      always_ff @(posedge i_core_clk) begin
         if (wr_now && !lanes_reg[l]) begin
            cell_reg[cur_addr] <= wr_cell;
         end
      end
      // forward bytes landing now, else back-to-back reads go stale
      assign {rd_par_next[l], rd_data_next[l*BYTE_W +: BYTE_W]} =
         (wr_hit && !lanes_reg[l]) ? wr_cell : cell_reg[rd_addr];
   end

   // read data registered: valid in cycle after address capture
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rd_data_reg <= '0;
         rd_par_reg <= '0;
      end else if (qual) begin
         rd_data_reg <= rd_data_next;
         rd_par_reg <= rd_par_next;
      end
   end

   // ----------------------------------------
   // output drive
   // ----------------------------------------
   always_comb begin
      bus.mem_dq_o = rd_data_reg;
      bus.mem_par_o = rd_par_reg;
      // release on write, wake, deselect regardless of enable
      bus.mem_drive_n = bus.output_enable_n || !active_reg
                        || is_write_reg || wake_reg;
   end
endmodule

// File: hw/sram_port_host.sv
`timescale 1ns/100ps
module sram_port_host
   import sram_port_pkg::*;
(
   input wire logic i_core_clk,             // interface clock
   input wire logic i_sys_rst,              // sync reset, active high
   input wire logic i_req_valid,            // request present
   input wire host_op_e i_req_op,           // operation
   input wire logic [ADDR_W-1:0] i_req_addr,  // start address
   input wire logic [LANES-1:0] i_req_lanes_n, // lane selects, low writes
   input wire logic [DATA_W-1:0] i_req_data,  // write data
   input wire logic [LANES-1:0] i_req_par,    // write parity
   input wire logic i_stall,                // hold the qualifier high
   input wire logic i_interleaved,          // burst order strap
   output logic o_req_ready,                // request accepted this cycle
   output logic o_rd_valid,                 // read data valid pulse
   output logic [DATA_W-1:0] o_rd_data,     // read data
   output logic [LANES-1:0] o_rd_par,       // read parity
   sram_port_if.host bus                    // link to memory
);
   logic [1:0] op_reg;
   logic [1:0] op_prev_reg;
   logic [DATA_W-1:0] wdata_reg;
   logic [LANES-1:0] wpar_reg;
   logic rd_valid_reg;
   logic [DATA_W-1:0] rd_data_reg;
   logic [LANES-1:0] rd_par_reg;
   logic take;

   assign o_req_ready = !i_stall;
   assign take = i_req_valid && !i_stall;
   assign o_rd_valid = rd_valid_reg;
   assign o_rd_data = rd_data_reg;
   assign o_rd_par = rd_par_reg;

   // ----------------------------------------
   // command pins, combinational from request
   // ----------------------------------------
   always_comb begin
      bus.clock_qualifier_n = i_stall;
      bus.addr = i_req_addr;
      bus.burst_order_interleaved = i_interleaved;
      bus.write_select_n = i_req_lanes_n;
      bus.output_enable_n = 1'b0;
      // idle deselects with load low so next access loads an address
      bus.advance_or_load = take && (i_req_op == OP_BURST);
      bus.write_strobe_n = !(take && (i_req_op == OP_WRITE));
      bus.chip_select_primary_n = !take;
      bus.chip_select_second = take;
      bus.chip_select_third_n = !take;
   end

   // ----------------------------------------
   // pipeline of one data phase
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         op_reg <= OP_IDLE;
         op_prev_reg <= OP_IDLE;
         wdata_reg <= '0;
         wpar_reg <= '0;
      end else if (!i_stall) begin
         op_prev_reg <= op_reg;
         if (!take) begin
            op_reg <= OP_IDLE;
         end else if (i_req_op == OP_BURST) begin
            op_reg <= (op_reg == OP_IDLE) ? OP_IDLE : op_reg;
         end else begin
            op_reg <= i_req_op;
         end
         wdata_reg <= i_req_data;
         wpar_reg <= i_req_par;
      end
   end

   always_comb begin
      bus.host_dq_o = wdata_reg;
      bus.host_par_o = wpar_reg;
      bus.host_drive_n = !(op_reg == OP_WRITE);
   end

   // read data arrives at the edge after its data phase
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rd_valid_reg <= 1'b0;
         rd_data_reg <= '0;
         rd_par_reg <= '0;
      end else begin
         rd_valid_reg <= !i_stall && (op_reg == OP_READ);
         if (!i_stall && op_reg == OP_READ) begin
            rd_data_reg <= bus.dq_wire;
            rd_par_reg <= bus.par_wire;
         end
      end
   end
endmodule

// File: test/sram_port_sva.sv
`timescale 1ns/100ps
module sram_port_sva
   import sram_port_pkg::*;
(
   input wire logic i_core_clk, // interface clock
   input wire logic i_sys_rst, // sync reset
   input wire logic write_strobe_n, // write strobe
   input wire logic advance_or_load, // burst step
   input wire logic clock_qualifier_n, // edge qualifier
   input wire logic chip_select_primary_n, // select 1
   input wire logic chip_select_second, // select 2
   input wire logic chip_select_third_n, // select 3
   input wire logic output_enable_n, // output enable
   input wire logic burst_order_interleaved, // order strap
   input wire logic [DATA_W-1:0] mem_dq_o, // memory data
   input wire logic mem_drive_n, // memory drives, low
   input wire logic host_drive_n // host drives, low
);
   // ----------------------------------------
   // wire protocol
   // ----------------------------------------
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   logic sel;
   assign sel = !chip_select_primary_n && chip_select_second
                && !chip_select_third_n;
   sequence s_sel; !clock_qualifier_n && sel; endsequence
   sequence s_desel; !clock_qualifier_n && !sel; endsequence
   sequence s_wr; s_sel ##0 !write_strobe_n; endsequence
   sequence s_rd;
      s_sel ##0 (!advance_or_load && write_strobe_n && !output_enable_n);
   endsequence
   AST_DESEL_RELEASE: assert property (s_desel |=> mem_drive_n)
      else $error("memory drives while deselected");
   AST_WRITE_RELEASE: assert property (s_wr |=> mem_drive_n)
      else $error("memory drives in write data phase");
   AST_READ_DRIVE: assert property (s_sel ##1 s_rd |=> !mem_drive_n)
      else $error("read data not driven one cycle later");
   AST_FREEZE: assert property (clock_qualifier_n
      |=> $stable(mem_drive_n) && $stable(mem_dq_o))
      else $error("memory moved on an unqualified edge");
   AST_NO_CLASH: assert property (mem_drive_n || host_drive_n)
      else $error("both ends drive the data wire");
   AST_HOST_WDATA: assert property (s_wr |=> !host_drive_n)
      else $error("host missed write data phase");
   AST_HOST_RD_RELEASE: assert property (s_rd |=> host_drive_n)
      else $error("host drives during read data");
   AST_LOAD_AFTER_DESEL: assert property (s_desel ##1 s_sel
      |-> !advance_or_load)
      else $error("burst step right after deselect");
   AST_STRAP_STEADY: assert property (s_sel ##0 advance_or_load
      |-> $stable(burst_order_interleaved))
      else $error("burst order changed in a burst");
endmodule

// File: test/pipelined_sync_sram_port_tb.sv
`timescale 1ns/100ps
module pipelined_sync_sram_port_tb;
   import sram_port_pkg::*;
   logic i_core_clk, i_sys_rst, i_req_valid, i_stall, i_interleaved;
   host_op_e i_req_op;
   logic [ADDR_W-1:0] i_req_addr;
   logic [LANES-1:0] i_req_lanes_n, i_req_par, o_rd_par;
   logic [DATA_W-1:0] i_req_data, o_rd_data;
   logic o_req_ready, o_rd_valid;
   logic [DATA_W+LANES-1:0] model [DEPTH];
   logic [DATA_W+LANES-1:0] exp_q [$];
   int fails, tests_run;
   sram_port_if bus();
   sram_port_memory i_sram_port_memory(.i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst), .bus(bus));
   sram_port_host i_sram_port_host(.i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst), .i_req_valid(i_req_valid),
      .i_req_op(i_req_op), .i_req_addr(i_req_addr),
      .i_req_lanes_n(i_req_lanes_n), .i_req_data(i_req_data),
      .i_req_par(i_req_par), .i_stall(i_stall),
      .i_interleaved(i_interleaved), .o_req_ready(o_req_ready),
      .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
      .o_rd_par(o_rd_par), .bus(bus));
   sram_port_sva i_sram_port_sva(.i_core_clk(i_core_clk),
      .i_sys_rst(i_sys_rst), .write_strobe_n(bus.write_strobe_n),
      .advance_or_load(bus.advance_or_load),
      .clock_qualifier_n(bus.clock_qualifier_n),
      .chip_select_primary_n(bus.chip_select_primary_n),
      .chip_select_second(bus.chip_select_second),
      .chip_select_third_n(bus.chip_select_third_n),
      .output_enable_n(bus.output_enable_n),
      .burst_order_interleaved(bus.burst_order_interleaved),
      .mem_dq_o(bus.mem_dq_o), .mem_drive_n(bus.mem_drive_n),
      .host_drive_n(bus.host_drive_n));
   // ----------------------------------------
   // access tasks
   // ----------------------------------------
   task automatic complete_run();
      $display("compares %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk(input logic [DATA_W+LANES-1:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   // request held through a stall so it is taken exactly once
   task automatic issue(input host_op_e op, input logic [ADDR_W-1:0] a,
      input logic [LANES-1:0] ln, input logic [DATA_W+LANES-1:0] d,
      input int st);
      @(negedge i_core_clk);
      i_req_valid = 1'b1;
      i_req_op = op;
      i_req_addr = a;
      i_req_lanes_n = ln;
      {i_req_par, i_req_data} = d;
      if (st != 0) begin
         i_stall = 1'b1;
         repeat (st) @(negedge i_core_clk);
         chk(36'(o_req_ready), 36'h0);
         i_stall = 1'b0;
      end
      @(posedge i_core_clk);
      chk(36'(o_req_ready), 36'h1);
   endtask
   task automatic idle();
      @(negedge i_core_clk);
      i_req_valid = 1'b0;
      i_req_op = OP_IDLE;
   endtask
   task automatic wr1(input logic [ADDR_W-1:0] a, input logic [3:0] ln,
      input logic [DATA_W+LANES-1:0] d);
      issue(OP_WRITE, a, ln, d, 0);
      for (int l = 0; l < LANES; l++) begin
         if (!ln[l]) begin
            model[a][BYTE_W*l +: BYTE_W] = d[BYTE_W*l +: BYTE_W];
            model[a][DATA_W+l] = d[DATA_W+l];
         end
      end
   endtask
   task automatic rd1(input logic [ADDR_W-1:0] a, input int st);
      issue(OP_READ, a, LANES_OFF, '0, st);
      exp_q.push_back(model[a]);
   endtask
   task automatic burst(input host_op_e op, input logic [ADDR_W-1:0] a,
      input int st);
      logic [ADDR_W-1:0] b;
      logic [DATA_W+LANES-1:0] d;
      for (int k = 0; k < 4; k++) begin
         b = i_interleaved ? a ^ k[7:0] : {a[7:2], a[1:0] + k[1:0]};
         d = {k[3:0], b, ~b, b ^ 8'h3c, 8'ha5};
         issue(k == 0 ? op : OP_BURST, a, 4'h0, d, k == 2 ? st : 0);
         if (op == OP_WRITE) model[b] = d;
         else exp_q.push_back(model[b]);
      end
   endtask
   // ----------------------------------------
   // clock, checks, scenarios
   // ----------------------------------------
   initial begin
      i_core_clk = 1'b0;
      forever #50 i_core_clk = ~i_core_clk;
   end
   always @(negedge i_core_clk) begin
      if (o_rd_valid === 1'b1 && exp_q.size() == 0) begin
         fails++;
         $display("[FAIL] %0t unexpected read data", $time);
      end else if (o_rd_valid === 1'b1) begin
         chk({o_rd_par, o_rd_data}, exp_q.pop_front());
      end
   end
   initial begin
      repeat (3000) @(posedge i_core_clk);
      fails++;
      complete_run();
   end
   initial begin
      logic [ADDR_W-1:0] a;
      {i_sys_rst, i_req_valid, i_stall, i_interleaved} = 4'h8;
      {i_req_addr, i_req_lanes_n, i_req_data, i_req_par} = '0;
      i_req_op = OP_IDLE;
      repeat (16) @(posedge i_core_clk);
      @(negedge i_core_clk);
      i_sys_rst = 1'b0;
      for (int m = 0; m < 2; m++) begin
         a = m ? 8'h96 : 8'h12;
         idle();
         i_interleaved = m[0];
         idle();
         burst(OP_WRITE, a, 2);
         idle();
         for (int k = 0; k < 4; k++) rd1({a[7:2], k[1:0]}, 0);
         burst(OP_READ, a ^ 8'h01, 3);
         idle();
      end
      wr1(8'h12, 4'ha, 36'h9_1122_3344);
      rd1(8'h12, 2);
      wr1(8'h13, 4'h5, 36'h6_5566_7788);
      rd1(8'h13, 0);
      idle();
      repeat (8) @(posedge i_core_clk);
      chk(36'(exp_q.size()), '0);
      complete_run();
   end
endmodule
